// ### hdl/clock_status_pkg.sv
// Purpose: Constants for the clock status and interrupt register block.
// Assumes: APB slave with 32-bit data, one aligned word per register.
// Notes: Bit positions are shared by the command, mask and status views.
// Operation
// - Writing one to an enable command bit enables that interrupt; zero does nothing.
// - Writing one to a disable command bit disables that interrupt; zero does nothing.
// - Mask view reads zero for enabled and one for disabled interrupts.
// - Status bit 0 reads one once the main oscillator is stable.
// - Status bit 1 reads one while PLL A is locked.
// - Status bit 2 reads one while PLL B is locked.
// - Status bit 3 reads one while the master clock is ready.
// - Status bit 7 reads zero for internal RC, one for external crystal.
// - Status bits 8 and 9 read one while programmable clock 0 or 1 is ready.
// - PLL A lock sets on the slow clock rising edge after the programmed count has run down, one edge more than the count since configuration.
`default_nettype none

package clock_status_pkg;

    localparam int unsigned ADDR_W        = 8;

    ////////////////////////////////////////////////////////////////////////////////
    localparam logic [7:0]  OFS_INT_ENABLE  = 8'h00;
    localparam logic [7:0]  OFS_INT_DISABLE = 8'h04;
    localparam logic [7:0]  OFS_STATUS      = 8'h08;
    localparam logic [7:0]  OFS_MASK_VIEW   = 8'h0c;
    localparam logic [7:0]  OFS_PUMP        = 8'h10;
    localparam logic [7:0]  OFS_PLL_A_CFG   = 8'h14;
    localparam logic [7:0]  OFS_EVENTS      = 8'h18;

    ////////////////////////////////////////////////////////////////////////////////
    localparam int unsigned BIT_OSC_STABLE  = 0;
    localparam int unsigned BIT_PLL_A_LOCK  = 1;
    localparam int unsigned BIT_PLL_B_LOCK  = 2;
    localparam int unsigned BIT_MCK_READY   = 3;
    localparam int unsigned BIT_SLOW_SRC    = 7;
    localparam int unsigned BIT_PCK0_READY  = 8;
    localparam int unsigned BIT_PCK1_READY  = 9;

    localparam logic [31:0] INT_BITS        = 32'h0000_030f;
    localparam logic [31:0] PUMP_BITS       = 32'h0001_0001;
    localparam logic [31:0] RESET_ENABLES   = 32'h0000_0000;
    localparam logic [31:0] RESET_PUMP      = 32'h0000_0000;
    localparam logic [31:0] RESET_PLL_A_CFG = 32'h2000_0000;

    localparam int unsigned LOCK_CNT_LSB    = 8;
    localparam int unsigned LOCK_CNT_W      = 6;

    ////////////////////////////////////////////////////////////////////////////////
    localparam int unsigned SYNC_W          = 7;
    localparam int unsigned SY_OSC          = 0;
    localparam int unsigned SY_PLL_B        = 1;
    localparam int unsigned SY_MCK          = 2;
    localparam int unsigned SY_PCK0         = 3;
    localparam int unsigned SY_PCK1         = 4;
    localparam int unsigned SY_SLOW_SRC     = 5;
    localparam int unsigned SY_SLOW_CLK     = 6;

endpackage : clock_status_pkg

`default_nettype wire

// ### hdl/level_sync.sv
// Purpose: Two-stage synchroniser for a bank of asynchronous levels.
// Assumes: Inputs are slow levels; no bus coherency across bits is needed.
// Notes: The first stage feeds only the second stage.
`default_nettype none

module level_sync #(
    parameter int unsigned WIDTH = 1
) (
    input  wire logic             clock_i,
    input  wire logic             nrst_i,
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] held;
    } sync_state_s;

    sync_state_s state_q;
    sync_state_s state_d;

    always_comb begin
        state_d      = state_q;
        state_d.meta = async_i;
        state_d.held = state_q.meta;
    end

    always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign sync_o = state_q.held;

endmodule : level_sync

`default_nettype wire

// ### hdl/clock_status_interrupt_regs.sv
// Purpose: Clock status, interrupt mask and pump current registers on APB.
// Assumes: Status levels arrive from other clock domains; the slow clock is sampled.
// Notes: One wait state on every transfer so that all bus outputs are registered.
//
// Added by the designer: register access over APB and the register offsets.
`default_nettype none

module clock_status_interrupt_regs (
    input  wire logic        clock_i,
    input  wire logic        nrst_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    input  wire logic        main_osc_stable_i,
    input  wire logic        pll_b_locked_i,
    input  wire logic        master_clk_ready_i,
    input  wire logic [1:0]  prog_clk_ready_i,
    input  wire logic        slow_osc_source_i,
    input  wire logic        slow_clk_i,
    output logic             irq_o,
    output logic [31:0]      pll_a_config_o,
    output logic             pll_a_pump_current_o,
    output logic             pll_b_pump_current_o
);

    ////////////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
        logic        irq;
        logic [31:0] enables;
        logic [31:0] events;
        logic [31:0] status_prev;
        logic [31:0] pump;
        logic [31:0] pll_a_cfg;
        logic [clock_status_pkg::LOCK_CNT_W-1:0] lock_cnt;
        logic        lock_pending;
        logic        pll_a_locked;
        logic        slow_prev;
    } regs_state_s;

    localparam regs_state_s RESET_STATE = '{
        pready:       1'b0,
        pslverr:      1'b0,
        prdata:       32'h0000_0000,
        irq:          1'b0,
        enables:      clock_status_pkg::RESET_ENABLES,
        events:       32'h0000_0000,
        status_prev:  32'h0000_0000,
        pump:         clock_status_pkg::RESET_PUMP,
        pll_a_cfg:    clock_status_pkg::RESET_PLL_A_CFG,
        lock_cnt:     '0,
        lock_pending: 1'b0,
        pll_a_locked: 1'b0,
        slow_prev:    1'b0
    };

    regs_state_s state_q;
    regs_state_s state_d;

    logic [clock_status_pkg::SYNC_W-1:0] sync_lvl;
    logic [31:0]                         status_now;
    logic [31:0]                         read_word;
    logic                                addr_hit;
    logic                                access;
    logic                                wr_fire;
    logic                                slow_edge;

    ////////////////////////////////////////////////////////////////////////////////
    // Clock-domain levels and the slow clock are resynchronised before any use.
    level_sync #(
        .WIDTH (clock_status_pkg::SYNC_W)
    ) u_level_sync (
        .clock_i (clock_i),
        .nrst_i  (nrst_i),
        .async_i ({slow_clk_i, slow_osc_source_i, prog_clk_ready_i,
                   master_clk_ready_i, pll_b_locked_i, main_osc_stable_i}),
        .sync_o  (sync_lvl)
    );

    assign slow_edge = sync_lvl[clock_status_pkg::SY_SLOW_CLK] & ~state_q.slow_prev;
    assign access    = psel_i & penable_i & ~state_q.pready;
    assign wr_fire   = psel_i & penable_i & state_q.pready & pwrite_i & ~state_q.pslverr;

    ////////////////////////////////////////////////////////////////////////////////
    always_comb begin
        status_now = 32'h0000_0000;
        status_now[clock_status_pkg::BIT_OSC_STABLE] = sync_lvl[clock_status_pkg::SY_OSC];
        status_now[clock_status_pkg::BIT_PLL_A_LOCK] = state_q.pll_a_locked;
        status_now[clock_status_pkg::BIT_PLL_B_LOCK] = sync_lvl[clock_status_pkg::SY_PLL_B];
        status_now[clock_status_pkg::BIT_MCK_READY]  = sync_lvl[clock_status_pkg::SY_MCK];
        status_now[clock_status_pkg::BIT_SLOW_SRC]   = sync_lvl[clock_status_pkg::SY_SLOW_SRC];
        status_now[clock_status_pkg::BIT_PCK0_READY] = sync_lvl[clock_status_pkg::SY_PCK0];
        status_now[clock_status_pkg::BIT_PCK1_READY] = sync_lvl[clock_status_pkg::SY_PCK1];
    end

    always_comb begin
        addr_hit  = 1'b1;
        read_word = 32'h0000_0000;
        case (paddr_i)
            clock_status_pkg::OFS_INT_ENABLE:  read_word = 32'h0000_0000;
            clock_status_pkg::OFS_INT_DISABLE: read_word = 32'h0000_0000;
            clock_status_pkg::OFS_STATUS:      read_word = status_now;
            clock_status_pkg::OFS_MASK_VIEW:
                read_word = ~state_q.enables & clock_status_pkg::INT_BITS;
            clock_status_pkg::OFS_PUMP:        read_word = 32'h0000_0000;
            clock_status_pkg::OFS_PLL_A_CFG:   read_word = state_q.pll_a_cfg;
            clock_status_pkg::OFS_EVENTS:      read_word = state_q.events;
            default:                           addr_hit  = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    always_comb begin
        state_d           = state_q;
        state_d.slow_prev = sync_lvl[clock_status_pkg::SY_SLOW_CLK];

        // Bus side: the first access cycle captures the answer, the second completes.
        state_d.pready  = 1'b0;
        state_d.pslverr = 1'b0;
        if (access) begin
            state_d.pready  = 1'b1;
            state_d.pslverr = ~addr_hit;
            state_d.prdata  = pwrite_i ? 32'h0000_0000 : read_word;
        end

        // Lock countdown on slow clock edges.
        if (state_q.lock_pending && slow_edge) begin
            if (state_q.lock_cnt == '0) begin
                state_d.pll_a_locked = 1'b1;
                state_d.lock_pending = 1'b0;
            end else begin
                state_d.lock_cnt = state_q.lock_cnt - 1'b1;
            end
        end

        // Sticky events: a new rising level wins over a clear in the same cycle.
        state_d.status_prev = status_now;
        state_d.events      = state_q.events;
        if (wr_fire && paddr_i == clock_status_pkg::OFS_EVENTS) begin
            state_d.events = state_q.events & ~pwdata_i;
        end
        state_d.events = state_d.events
                       | (status_now & ~state_q.status_prev & clock_status_pkg::INT_BITS);

        if (wr_fire) begin
            case (paddr_i)
                clock_status_pkg::OFS_INT_ENABLE: begin
                    state_d.enables = state_q.enables
                                    | (pwdata_i & clock_status_pkg::INT_BITS);
                end
                clock_status_pkg::OFS_INT_DISABLE: begin
                    state_d.enables = state_q.enables
                                    & ~(pwdata_i & clock_status_pkg::INT_BITS);
                end
                clock_status_pkg::OFS_PUMP: begin
                    // The PLL B current is held as written; software is expected to keep it zero.
                    state_d.pump = pwdata_i & clock_status_pkg::PUMP_BITS;
                end
                clock_status_pkg::OFS_PLL_A_CFG: begin
                    state_d.pll_a_cfg    = pwdata_i;
                    state_d.lock_cnt     = pwdata_i[clock_status_pkg::LOCK_CNT_LSB +:
                                                    clock_status_pkg::LOCK_CNT_W];
                    state_d.lock_pending = 1'b1;
                    state_d.pll_a_locked = 1'b0;
                end
                default: begin
                    // Status and mask view are read-only, so the write is dropped.
                    state_d.enables = state_q.enables;
                end
            endcase
        end

        // Levels keep the line high; events also catch pulses shorter than a poll.
        state_d.irq = |((status_now | state_q.events) & state_q.enables
                        & clock_status_pkg::INT_BITS);
    end

    always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
            state_q <= RESET_STATE;
        end else begin
            state_q <= state_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    assign prdata_o             = state_q.prdata;
    assign pready_o             = state_q.pready;
    assign pslverr_o            = state_q.pslverr;
    assign irq_o                = state_q.irq;
    assign pll_a_config_o       = state_q.pll_a_cfg;
    assign pll_a_pump_current_o = state_q.pump[0];
    assign pll_b_pump_current_o = state_q.pump[16];

    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!nrst_i);

    logic rd_done;
    assign rd_done = psel_i & penable_i & state_q.pready & ~pwrite_i;

    logic [31:0] rise_bits;
    assign rise_bits = status_now & ~state_q.status_prev & clock_status_pkg::INT_BITS;

    sequence s_cfg_write;
        wr_fire && paddr_i == clock_status_pkg::OFS_PLL_A_CFG;
    endsequence

    sequence s_cmd_write(logic [7:0] ofs);
        wr_fire && paddr_i == ofs;
    endsequence

    a_enable_sets: assert property (
        s_cmd_write(clock_status_pkg::OFS_INT_ENABLE) |=>
            state_q.enables == ($past(state_q.enables)
                               | ($past(pwdata_i) & clock_status_pkg::INT_BITS)))
        else $error("enable command did not set the written bits");

    a_disable_clears: assert property (
        s_cmd_write(clock_status_pkg::OFS_INT_DISABLE) |=>
            state_q.enables == ($past(state_q.enables)
                               & ~($past(pwdata_i) & clock_status_pkg::INT_BITS)))
        else $error("disable command did not clear the written bits");

    a_mask_view_inv: assert property (
        rd_done && paddr_i == clock_status_pkg::OFS_MASK_VIEW |->
            prdata_o == (~state_q.enables & clock_status_pkg::INT_BITS))
        else $error("mask view does not read as inverted enables");

    a_status_osc: assert property (
        rd_done && paddr_i == clock_status_pkg::OFS_STATUS |->
            prdata_o[0] == $past(sync_lvl[clock_status_pkg::SY_OSC]))
        else $error("oscillator stable bit wrong");

    a_status_pll_a: assert property (
        rd_done && paddr_i == clock_status_pkg::OFS_STATUS |->
            prdata_o[1] == $past(state_q.pll_a_locked))
        else $error("pll a lock bit wrong");

    a_status_pll_b: assert property (
        rd_done && paddr_i == clock_status_pkg::OFS_STATUS |->
            prdata_o[2] == $past(sync_lvl[clock_status_pkg::SY_PLL_B]))
        else $error("pll b lock bit wrong");

    a_status_mck: assert property (
        rd_done && paddr_i == clock_status_pkg::OFS_STATUS |->
            prdata_o[3] == $past(sync_lvl[clock_status_pkg::SY_MCK]))
        else $error("master clock ready bit wrong");

    a_status_slow_src: assert property (
        rd_done && paddr_i == clock_status_pkg::OFS_STATUS |->
            prdata_o[7] == $past(sync_lvl[clock_status_pkg::SY_SLOW_SRC]))
        else $error("slow source bit wrong");

    a_status_pck: assert property (
        rd_done && paddr_i == clock_status_pkg::OFS_STATUS |->
            prdata_o[9:8] == $past({sync_lvl[clock_status_pkg::SY_PCK1],
                                    sync_lvl[clock_status_pkg::SY_PCK0]}))
        else $error("programmable clock ready bits wrong");

    a_lock_restarts: assert property (
        s_cfg_write |=> !state_q.pll_a_locked && state_q.lock_pending)
        else $error("configuration write did not restart the lock count");

    a_lock_timing: assert property (
        $rose(state_q.pll_a_locked) |->
            $past(state_q.lock_pending && state_q.lock_cnt == '0 && slow_edge))
        else $error("pll a lock set before the count elapsed");

    a_irq_level: assert property (
        ##1 irq_o == $past(|((status_now | state_q.events) & state_q.enables
                             & clock_status_pkg::INT_BITS)))
        else $error("interrupt output disagrees with enabled status");

    a_mask_stable: assert property (
        !(wr_fire && (paddr_i == clock_status_pkg::OFS_INT_ENABLE
                      || paddr_i == clock_status_pkg::OFS_INT_DISABLE))
            |=> $stable(state_q.enables))
        else $error("mask changed without a command write");

    a_ro_write_ignored: assert property (
        wr_fire && (paddr_i == clock_status_pkg::OFS_STATUS
                    || paddr_i == clock_status_pkg::OFS_MASK_VIEW) |=>
            $stable(state_q.enables) && $stable(state_q.pump) && $stable(state_q.pll_a_cfg))
        else $error("write to a read-only register changed state");

    // A rise and a clear in one cycle must leave the event set.
    a_event_set_wins: assert property (
        |rise_bits |=> (state_q.events & $past(rise_bits)) == $past(rise_bits))
        else $error("status rise did not set its event");

    a_lock_waits: assert property (
        state_q.lock_pending && state_q.lock_cnt != '0 |=> !state_q.pll_a_locked)
        else $error("pll a lock set with slow clock cycles still to run");

endmodule : clock_status_interrupt_regs

`default_nettype wire

// ### dv/tb.sv
// Purpose: Self-checking bench for the clock status and interrupt register block.
// Assumes: APB master here; status levels are driven straight from the bench.
// Notes: Status reads wait a few cycles so the input synchronisers have settled.
`default_nettype none

module tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clock_i;
    logic        nrst_i;
    logic        psel_i;
    logic        penable_i;
    logic        pwrite_i;
    logic [7:0]  paddr_i;
    logic [31:0] pwdata_i;
    logic [31:0] prdata_o;
    logic        pready_o;
    logic        pslverr_o;
    logic        main_osc_stable_i;
    logic        pll_b_locked_i;
    logic        master_clk_ready_i;
    logic [1:0]  prog_clk_ready_i;
    logic        slow_osc_source_i;
    logic        slow_clk_i;
    logic        irq_o;
    logic [31:0] pll_a_config_o;
    logic        pll_a_pump_current_o;
    logic        pll_b_pump_current_o;
    int          fails;
    int          n_tests;
    int          cycles;
    logic [31:0] rdata;
    logic        err;

    clock_status_interrupt_regs u_clock_status_interrupt_regs (
        .clock_i(clock_i), .nrst_i(nrst_i), .psel_i(psel_i), .penable_i(penable_i),
        .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o), .main_osc_stable_i(main_osc_stable_i),
        .pll_b_locked_i(pll_b_locked_i), .master_clk_ready_i(master_clk_ready_i),
        .prog_clk_ready_i(prog_clk_ready_i), .slow_osc_source_i(slow_osc_source_i),
        .slow_clk_i(slow_clk_i), .irq_o(irq_o), .pll_a_config_o(pll_a_config_o),
        .pll_a_pump_current_o(pll_a_pump_current_o),
        .pll_b_pump_current_o(pll_b_pump_current_o)
    );

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clock_i = 1'b0;
        forever #12.5 clock_i = ~clock_i;
    end

    // The ceiling is about thirty times the length of the sequence, so only a hang reaches it.
    always @(posedge clock_i) begin
        cycles <= cycles + 1;
        if (cycles == 8000) begin
            $display("mismatch timeout expected done seen hang");
            fails = fails + 1;
            give_verdict();
        end
    end

    task automatic give_verdict();
        if (fails == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : give_verdict

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_tests = n_tests + 1;
        if (got !== exp) begin
            $display("mismatch %s expected %h seen %h", name, exp, got);
            fails = fails + 1;
        end
    endtask : check

    ////////////////////////////////////////////////////////////////////////////////
    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wdata);
        @(posedge clock_i);
        psel_i    <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i  <= wr;
        paddr_i   <= addr;
        pwdata_i  <= wdata;
        @(posedge clock_i);
        penable_i <= 1'b1;
        // Only the bench timeout ends this wait, so a slave that never answers is caught there.
        do begin
            @(posedge clock_i);
        end while (pready_o !== 1'b1);
        rdata = prdata_o;
        err   = pslverr_o;
        psel_i    <= 1'b0;
        penable_i <= 1'b0;
    endtask : apb

    task automatic rd(input logic [7:0] addr, input logic [31:0] exp, input string name);
        apb(1'b0, addr, 32'h0000_0000);
        check(name, exp, rdata);
    endtask : rd

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clock_i);
    endtask : wait_clk

    task automatic set_in(input logic [5:0] v);
        @(posedge clock_i);
        main_osc_stable_i  <= v[0];
        pll_b_locked_i     <= v[1];
        master_clk_ready_i <= v[2];
        slow_osc_source_i  <= v[3];
        prog_clk_ready_i   <= v[5:4];
        wait_clk(5);
    endtask : set_in

    function automatic logic [31:0] stat(input logic [5:0] v, input logic lk);
        stat = 32'h0000_0000;
        stat[clock_status_pkg::BIT_OSC_STABLE] = v[0];
        stat[clock_status_pkg::BIT_PLL_A_LOCK] = lk;
        stat[clock_status_pkg::BIT_PLL_B_LOCK] = v[1];
        stat[clock_status_pkg::BIT_MCK_READY]  = v[2];
        stat[clock_status_pkg::BIT_SLOW_SRC]   = v[3];
        stat[clock_status_pkg::BIT_PCK0_READY] = v[4];
        stat[clock_status_pkg::BIT_PCK1_READY] = v[5];
    endfunction : stat

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset_and_mask();
        rd(clock_status_pkg::OFS_MASK_VIEW, 32'h0000_030f, "mask_reset");
        check("irq_reset", 32'h0, {31'h0, irq_o});
        apb(1'b1, clock_status_pkg::OFS_INT_ENABLE, 32'h0000_0105);
        rd(clock_status_pkg::OFS_MASK_VIEW, 32'h0000_020a, "mask_enable");
        apb(1'b1, clock_status_pkg::OFS_INT_ENABLE, 32'h0000_0000);
        rd(clock_status_pkg::OFS_MASK_VIEW, 32'h0000_020a, "mask_en_zero");
        apb(1'b1, clock_status_pkg::OFS_INT_DISABLE, 32'h0000_0101);
        rd(clock_status_pkg::OFS_MASK_VIEW, 32'h0000_030b, "mask_disable");
        apb(1'b1, clock_status_pkg::OFS_MASK_VIEW, 32'h0000_0000);
        apb(1'b1, clock_status_pkg::OFS_STATUS, 32'hffff_ffff);
        rd(clock_status_pkg::OFS_MASK_VIEW, 32'h0000_030b, "mask_ro");
        apb(1'b1, 8'h40, 32'h0000_030f);
        check("unmapped_err", 32'h1, {31'h0, err});
        rd(clock_status_pkg::OFS_MASK_VIEW, 32'h0000_030b, "mask_unmapped");
        apb(1'b1, clock_status_pkg::OFS_INT_DISABLE, 32'hffff_ffff);
        rd(clock_status_pkg::OFS_MASK_VIEW, 32'h0000_030f, "mask_all_off");
    endtask : t_reset_and_mask

    task automatic t_status_bits();
        for (int i = 0; i < 6; i++) begin
            set_in(6'h01 << i);
            rd(clock_status_pkg::OFS_STATUS, stat(6'h01 << i, 1'b0), "status_walk");
        end
        set_in(6'h3f);
        rd(clock_status_pkg::OFS_STATUS, stat(6'h3f, 1'b0), "status_all");
        check("irq_masked", 32'h0, {31'h0, irq_o});
        set_in(6'h00);
        rd(clock_status_pkg::OFS_STATUS, stat(6'h00, 1'b0), "status_none");
        apb(1'b1, clock_status_pkg::OFS_EVENTS, 32'h0000_030f);
    endtask : t_status_bits

    task automatic t_irq();
        apb(1'b1, clock_status_pkg::OFS_INT_ENABLE, 32'h0000_0008);
        wait_clk(2);
        check("irq_idle", 32'h0, {31'h0, irq_o});
        set_in(6'h04);
        check("irq_raise", 32'h1, {31'h0, irq_o});
        apb(1'b1, clock_status_pkg::OFS_INT_DISABLE, 32'h0000_0001);
        wait_clk(2);
        check("irq_other_off", 32'h1, {31'h0, irq_o});
        apb(1'b1, clock_status_pkg::OFS_INT_DISABLE, 32'h0000_0008);
        wait_clk(2);
        check("irq_masked_off", 32'h0, {31'h0, irq_o});
        apb(1'b1, clock_status_pkg::OFS_INT_ENABLE, 32'h0000_0008);
        set_in(6'h00);
        check("irq_sticky", 32'h1, {31'h0, irq_o});
        apb(1'b1, clock_status_pkg::OFS_EVENTS, 32'h0000_0008);
        wait_clk(2);
        check("irq_cleared", 32'h0, {31'h0, irq_o});
        apb(1'b1, clock_status_pkg::OFS_INT_DISABLE, 32'h0000_030f);
    endtask : t_irq

    task automatic slow_edge();
        @(posedge clock_i);
        slow_clk_i <= 1'b1;
        wait_clk(4);
        slow_clk_i <= 1'b0;
        wait_clk(4);
    endtask : slow_edge

    task automatic t_pll_lock();
        logic [31:0] cfg;
        cfg = 32'h2000_0000 | (32'd2 << clock_status_pkg::LOCK_CNT_LSB);
        apb(1'b1, clock_status_pkg::OFS_PLL_A_CFG, cfg);
        wait_clk(1);
        check("pll_a_config_o", cfg, pll_a_config_o);
        rd(clock_status_pkg::OFS_PLL_A_CFG, cfg, "pll_a_cfg_read");
        slow_edge();
        slow_edge();
        rd(clock_status_pkg::OFS_STATUS, stat(6'h00, 1'b0), "lock_early");
        slow_edge();
        rd(clock_status_pkg::OFS_STATUS, stat(6'h00, 1'b1), "lock_set");
        apb(1'b1, clock_status_pkg::OFS_PLL_A_CFG, cfg);
        rd(clock_status_pkg::OFS_STATUS, stat(6'h00, 1'b0), "lock_cleared");
    endtask : t_pll_lock

    task automatic t_pump();
        // Bit 16 stays zero, as software is required to write it.
        apb(1'b1, clock_status_pkg::OFS_PUMP, 32'h0000_0001);
        wait_clk(1);
        check("pump_a", 32'h1, {31'h0, pll_a_pump_current_o});
        check("pump_b", 32'h0, {31'h0, pll_b_pump_current_o});
        rd(clock_status_pkg::OFS_PUMP, 32'h0000_0000, "pump_read");
        check("pump_err", 32'h0, {31'h0, err});
    endtask : t_pump

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        fails = 0;
        n_tests = 0;
        cycles = 0;
        nrst_i = 1'b0;
        psel_i = 1'b0;
        penable_i = 1'b0;
        pwrite_i = 1'b0;
        paddr_i = 8'h00;
        pwdata_i = 32'h0000_0000;
        main_osc_stable_i = 1'b0;
        pll_b_locked_i = 1'b0;
        master_clk_ready_i = 1'b0;
        prog_clk_ready_i = 2'h0;
        slow_osc_source_i = 1'b0;
        slow_clk_i = 1'b0;
        wait_clk(20);
        nrst_i <= 1'b1;
        t_reset_and_mask();
        t_status_bits();
        t_irq();
        t_pll_lock();
        t_pump();
        give_verdict();
    end

endmodule : tb

`default_nettype wire
